// ==== pkg/ufc_pkg.sv ====
// Constants, register layout and state encoding of the function control block.
package ufc_pkg;

    // ****************************************************************
    // Register addresses and write styles
    // ****************************************************************
    localparam logic [5:0] UFC_ADDR_WRITE = 6'h04;
    localparam logic [5:0] UFC_ADDR_SET = 6'h05;
    localparam logic [5:0] UFC_ADDR_CLEAR = 6'h06;
    localparam logic [7:0] UFC_UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // Field positions and reset value
    // ****************************************************************
    localparam int UFC_BIT_RESERVED = 7;
    localparam int UFC_BIT_POWERED_N_LP = 6;
    localparam int UFC_BIT_CORE_RESET = 5;
    localparam int UFC_ENC_HI = 4;
    localparam int UFC_ENC_LO = 3;
    localparam int UFC_BIT_TERM = 2;
    localparam int UFC_SPEED_HI = 1;
    localparam int UFC_SPEED_LO = 0;
    localparam logic [7:0] UFC_FC_RESET = 8'h41;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0] UFC_ENC_NORMAL = 2'h0;
    localparam logic [1:0] UFC_ENC_NON_DRIVING = 2'h1;
    localparam logic [1:0] UFC_ENC_RAW_BITS = 2'h2;
    localparam logic [1:0] UFC_ENC_NO_SYNC_EOP = 2'h3;
    localparam logic [1:0] UFC_SPEED_HS = 2'h0;
    localparam logic [1:0] UFC_SPEED_FS = 2'h1;
    localparam logic [1:0] UFC_SPEED_LS = 2'h2;
    localparam logic [1:0] UFC_SPEED_LS_ON_FS = 2'h3;

    // ****************************************************************
    // Link command codes in the top two bits of a command byte
    // ****************************************************************
    localparam logic [1:0] UFC_CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] UFC_CMD_REG_READ = 2'h3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int UFC_CLK_MHZ = 40;
    localparam int UFC_CORE_RESET_NS = 1000;
    localparam int UFC_CORE_RESET_CYCLES = (UFC_CORE_RESET_NS * UFC_CLK_MHZ + 999) / 1000;
    localparam logic [5:0] UFC_CORE_RESET_LAST = 6'(UFC_CORE_RESET_CYCLES - 1);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        UFC_IDLE,
        UFC_WR_DATA,
        UFC_WR_STOP,
        UFC_RD_TURN,
        UFC_RD_DATA,
        UFC_RD_END,
        UFC_CORE_RST,
        UFC_RX_GAP,
        UFC_RX_TURN,
        UFC_RX_DATA,
        UFC_LOW_POWER
    } ufc_state_e;

endpackage : ufc_pkg

// ==== src/ufc_sync.sv ====
// Two-stage synchroniser for a group of levels entering the clk domain.
`timescale 1ns/1ps
`default_nettype none

module ufc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } ufc_sync_s;

    ufc_sync_s s_q;
    ufc_sync_s s_d;

    // The first stage feeds only the second stage, never logic.
    always_comb
    begin
        s_d.first = async_in;
        s_d.second = s_q.first;
    end

    // Both stages clear on reset.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.second;

endmodule : ufc_sync
`default_nettype wire

// ==== src/ufc_function_control.sv ====
// Function control register of the transceiver and the sequences it starts.
`timescale 1ns/1ps
`default_nettype none

module ufc_function_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ulpi_clk,
    input wire logic ulpi_stp,
    input wire logic [7:0] ulpi_data_in,
    output logic [7:0] ulpi_data_out,
    output logic ulpi_data_oe,
    output logic ulpi_dir,
    output logic ulpi_nxt,
    input wire logic [1:0] line_state,
    input wire logic plus_line_pulldown,
    input wire logic minus_line_pulldown,
    output logic [7:0] function_control,
    output logic phy_low_power,
    output logic core_reset,
    output logic [1:0] transmit_encoding_sel,
    output logic termination_sel,
    output logic [1:0] transceiver_speed_sel,
    output logic tx_non_driving,
    output logic bit_stuff_nrzi_en,
    output logic auto_sync_eop_en,
    output logic fs_preamble_en,
    output logic fs_pullup_en,
    output logic hs_term_en
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        ufc_pkg::ufc_state_e st;
        logic [7:0] fc;
        logic [5:0] cnt;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic lp_armed;
        logic clk_prev;
        logic dir;
        logic nxt;
        logic oe;
        logic [7:0] dout;
        logic lp;
        logic crst;
        logic non_drv;
        logic stuff_en;
        logic sync_eop_en;
        logic preamble;
        logic fs_pu;
        logic hs_term;
    } ufc_state_s;

    // Reset picture: link owns the bus, register at its default values.
    localparam ufc_state_s UFC_RESET_STATE = '{
        st: ufc_pkg::UFC_IDLE,
        fc: ufc_pkg::UFC_FC_RESET,
        cnt: 6'h00,
        addr: 6'h00,
        wdata: 8'h00,
        lp_armed: 1'b0,
        clk_prev: 1'b0,
        dir: 1'b0,
        nxt: 1'b0,
        oe: 1'b0,
        dout: 8'h00,
        lp: 1'b0,
        crst: 1'b0,
        non_drv: 1'b0,
        stuff_en: 1'b1,
        sync_eop_en: 1'b1,
        preamble: 1'b0,
        fs_pu: 1'b0,
        hs_term: 1'b0
    };

    ufc_state_s s_q;
    ufc_state_s s_d;
    logic [11:0] pins_sync;
    logic uclk;
    logic stp;
    logic [7:0] din;
    logic [1:0] ls;
    logic tick;
    logic fc_hit;
    logic [7:0] fc_new;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // The link clock is slow against clk, so every link pin and the line state are resampled here.
    ufc_sync #(
        .WIDTH(12)
    ) u_pins (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({ulpi_clk, ulpi_stp, ulpi_data_in, line_state}),
        .sync_out(pins_sync)
    );

    assign {uclk, stp, din, ls} = pins_sync;
    // Data and stop share the clock's latency, so they are stable at the edge.
    assign tick = uclk & ~s_q.clk_prev;

    // ****************************************************************
    // Register update
    // ****************************************************************
    // Three write addresses.
    assign fc_hit = (s_q.addr == ufc_pkg::UFC_ADDR_WRITE) ||
                    (s_q.addr == ufc_pkg::UFC_ADDR_SET) ||
                    (s_q.addr == ufc_pkg::UFC_ADDR_CLEAR);

    // OR for set; mask for clear.
    always_comb
    begin
        unique case (s_q.addr)
            ufc_pkg::UFC_ADDR_SET: fc_new = s_q.fc | s_q.wdata;
            ufc_pkg::UFC_ADDR_CLEAR: fc_new = s_q.fc & ~s_q.wdata;
            default: fc_new = s_q.wdata;
        endcase
    end

    // ****************************************************************
    // Sequencer and decoded outputs
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.clk_prev = uclk;
        unique case (s_q.st)
            ufc_pkg::UFC_IDLE:
            begin
                if (tick && din[7:6] == ufc_pkg::UFC_CMD_REG_WRITE)
                begin
                    s_d.addr = din[5:0];
                    s_d.nxt = 1'b1;
                    s_d.st = ufc_pkg::UFC_WR_DATA;
                end
                else if (tick && din[7:6] == ufc_pkg::UFC_CMD_REG_READ)
                begin
                    s_d.addr = din[5:0];
                    s_d.nxt = 1'b1;
                    s_d.st = ufc_pkg::UFC_RD_TURN;
                end
            end
            ufc_pkg::UFC_WR_DATA:
            begin
                if (tick)
                begin
                    s_d.wdata = din;
                    s_d.nxt = 1'b0;
                    s_d.st = ufc_pkg::UFC_WR_STOP;
                end
            end
            ufc_pkg::UFC_WR_STOP:
            begin
                // A write only lands when the link closes it with stop.
                if (tick)
                begin
                    s_d.st = ufc_pkg::UFC_IDLE;
                    if (stp && fc_hit)
                    begin
                        s_d.fc = fc_new;
                        if (fc_new[ufc_pkg::UFC_BIT_CORE_RESET])
                        begin
                            s_d.st = ufc_pkg::UFC_CORE_RST;
                            s_d.dir = 1'b1;
                            s_d.cnt = 6'h00;
                        end
                        else if (!fc_new[ufc_pkg::UFC_BIT_POWERED_N_LP])
                        begin
                            s_d.st = ufc_pkg::UFC_LOW_POWER;
                            s_d.dir = 1'b1;
                            s_d.lp_armed = 1'b0;
                        end
                    end
                end
            end
            ufc_pkg::UFC_RD_TURN:
            begin
                if (tick)
                begin
                    s_d.nxt = 1'b0;
                    s_d.dir = 1'b1;
                    s_d.st = ufc_pkg::UFC_RD_DATA;
                end
            end
            ufc_pkg::UFC_RD_DATA:
            begin
                // All three addresses read the register.
                if (tick)
                begin
                    s_d.oe = 1'b1;
                    s_d.dout = fc_hit ? s_q.fc : ufc_pkg::UFC_UNMAPPED_READ;
                    s_d.st = ufc_pkg::UFC_RD_END;
                end
            end
            ufc_pkg::UFC_RD_END, ufc_pkg::UFC_RX_DATA:
            begin
                if (tick)
                begin
                    s_d.dir = 1'b0;
                    s_d.oe = 1'b0;
                    s_d.dout = 8'h00;
                    s_d.st = ufc_pkg::UFC_IDLE;
                end
            end
            ufc_pkg::UFC_CORE_RST:
            begin
                // Only the core is held; the register keeps its value.
                s_d.cnt = s_q.cnt + 6'h01;
                if (s_q.cnt == ufc_pkg::UFC_CORE_RESET_LAST)
                begin
                    s_d.fc[ufc_pkg::UFC_BIT_CORE_RESET] = 1'b0;
                    s_d.dir = 1'b0;
                    s_d.st = ufc_pkg::UFC_RX_GAP;
                end
            end
            ufc_pkg::UFC_RX_GAP:
            begin
                if (tick)
                begin
                    s_d.dir = 1'b1;
                    s_d.st = ufc_pkg::UFC_RX_TURN;
                end
            end
            ufc_pkg::UFC_RX_TURN:
            begin
                if (tick)
                begin
                    s_d.oe = 1'b1;
                    s_d.dout = {6'h00, ls};
                    s_d.st = ufc_pkg::UFC_RX_DATA;
                end
            end
            ufc_pkg::UFC_LOW_POWER:
            begin
                // The link clock may stop here, so stop is watched without tick.
                // The closing stop of the write is let go before a new one counts.
                if (!stp)
                begin
                    s_d.lp_armed = 1'b1;
                end
                // Stop wakes; bit back to one.
                else if (s_q.lp_armed)
                begin
                    s_d.fc[ufc_pkg::UFC_BIT_POWERED_N_LP] = 1'b1;
                    s_d.dir = 1'b0;
                    s_d.st = ufc_pkg::UFC_IDLE;
                end
            end
        endcase

        s_d.lp = (s_d.st == ufc_pkg::UFC_LOW_POWER);
        s_d.crst = (s_d.st == ufc_pkg::UFC_CORE_RST);
        s_d.non_drv = (s_d.fc[4:3] == ufc_pkg::UFC_ENC_NON_DRIVING);
        s_d.stuff_en = (s_d.fc[4:3] != ufc_pkg::UFC_ENC_RAW_BITS);
        s_d.sync_eop_en = (s_d.fc[4:3] != ufc_pkg::UFC_ENC_NO_SYNC_EOP);
        s_d.preamble = (s_d.fc[1:0] == ufc_pkg::UFC_SPEED_LS_ON_FS);
        // Termination depends on speed, mode, pull-downs.
        s_d.fs_pu = !s_d.non_drv && s_d.fc[ufc_pkg::UFC_BIT_TERM] &&
                    !plus_line_pulldown && !minus_line_pulldown;
        s_d.hs_term = !s_d.non_drv && !s_d.fc[ufc_pkg::UFC_BIT_TERM] &&
                      (s_d.fc[1:0] == ufc_pkg::UFC_SPEED_HS);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= UFC_RESET_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs, all taken from the state record
    // ****************************************************************
    assign ulpi_data_out = s_q.dout;
    assign ulpi_data_oe = s_q.oe;
    assign ulpi_dir = s_q.dir;
    assign ulpi_nxt = s_q.nxt;
    assign function_control = s_q.fc;
    assign phy_low_power = s_q.lp;
    assign core_reset = s_q.crst;
    assign transmit_encoding_sel = s_q.fc[ufc_pkg::UFC_ENC_HI:ufc_pkg::UFC_ENC_LO];
    assign termination_sel = s_q.fc[ufc_pkg::UFC_BIT_TERM];
    // Speed field drives the transceiver choice.
    assign transceiver_speed_sel = s_q.fc[ufc_pkg::UFC_SPEED_HI:ufc_pkg::UFC_SPEED_LO];
    assign tx_non_driving = s_q.non_drv;
    assign bit_stuff_nrzi_en = s_q.stuff_en;
    assign auto_sync_eop_en = s_q.sync_eop_en;
    assign fs_preamble_en = s_q.preamble;
    assign fs_pullup_en = s_q.fs_pu;
    assign hs_term_en = s_q.hs_term;
    // Bit 7 is stored and read back but drives nothing.

endmodule : ufc_function_control
`default_nettype wire

// ==== tb/ufc_fc_chk.sv ====
// Port-level assertions for the function control block.
`timescale 1ns/1ps
`default_nettype none

module ufc_fc_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ulpi_dir,
    input wire logic [7:0] function_control,
    input wire logic phy_low_power,
    input wire logic core_reset,
    input wire logic [1:0] transmit_encoding_sel,
    input wire logic termination_sel,
    input wire logic [1:0] transceiver_speed_sel,
    input wire logic tx_non_driving,
    input wire logic auto_sync_eop_en,
    input wire logic fs_preamble_en,
    input wire logic hs_term_en
);
    // ****
    // Core reset length
    // ****
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;

    // Counts clocks in core reset, so a short or long reset is seen.
    always_comb
    begin
        cnt_d = core_reset ? cnt_q + 7'h01 : 7'h00;
    end

    always_ff @(posedge clk)
    begin
        cnt_q <= rst_n ? cnt_d : 7'h00;
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    reset_value_a:
        assert property ($rose(rst_n) |-> function_control == ufc_pkg::UFC_FC_RESET && !core_reset)
        else $error("register not at reset value");
    core_dir_a:
        assert property (core_reset |-> ulpi_dir) else $error("bus not held in core reset");
    core_spares_a:
        assert property (core_reset && $past(core_reset) |-> $stable(function_control))
        else $error("register changed in core reset");
    core_done_a:
        assert property ($fell(core_reset) |-> !function_control[5] && !ulpi_dir)
        else $error("reset bit or dir not released");
    core_len_a:
        assert property ($fell(core_reset) |-> cnt_q == 7'(ufc_pkg::UFC_CORE_RESET_CYCLES))
        else $error("core reset length");
    lp_entry_a:
        assert property ($rose(phy_low_power) |-> !function_control[6] && ulpi_dir)
        else $error("low power without suspend bit");
    lp_exit_a:
        assert property ($fell(phy_low_power) |-> function_control[6])
        else $error("suspend bit not restored");
    field_map_a:
        assert property ({transmit_encoding_sel, termination_sel, transceiver_speed_sel}
            == function_control[4:0]) else $error("fields differ from register");
    non_drive_a:
        assert property (tx_non_driving == (transmit_encoding_sel == 2'h1))
        else $error("non-driving decode");
    sync_eop_a:
        assert property (auto_sync_eop_en == (transmit_encoding_sel != 2'h3))
        else $error("sync and eop decode");
    preamble_a:
        assert property (fs_preamble_en == (transceiver_speed_sel == 2'h3))
        else $error("preamble decode");
    hs_term_a:
        assert property (hs_term_en == (!tx_non_driving && !termination_sel &&
            transceiver_speed_sel == 2'h0)) else $error("high-speed termination decode");
endmodule : ufc_fc_chk

`default_nettype wire

// ==== tb/ufc_link_model.sv ====
// Link controller model driving the transceiver bus from the far side.
`timescale 1ns/1ps
`default_nettype none

module ufc_link_model (
    output logic ulpi_clk,
    output logic ulpi_stp,
    output logic [7:0] link_data,
    input wire logic ulpi_nxt,
    input wire logic phy_low_power,
    input wire logic [7:0] bus_data
);
    // Idle link: clock still, stop low, bus low.
    initial
    begin
        ulpi_clk = 1'b0;
        ulpi_stp = 1'b0;
        link_data = 8'h00;
    end

    // One link cycle; released lines toggle so stale data never matches.
    task automatic cyc(input logic [7:0] d, input logic s, input logic drive);
        link_data = drive ? d : ~link_data;
        ulpi_stp = s;
        #100;
        ulpi_clk = 1'b1;
        #100;
        ulpi_clk = 1'b0;
    endtask : cyc

    // Three cycles with the bus handed to the device; data sampled mid-way.
    task automatic turn3(output logic [7:0] v);
        cyc(8'h00, 1'b0, 1'b0);
        cyc(8'h00, 1'b0, 1'b0);
        v = bus_data;
        cyc(8'h00, 1'b0, 1'b0);
    endtask : turn3

    // Write frame: command, data, then stop closes it.
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d, output logic nx);
        #7;
        cyc({ufc_pkg::UFC_CMD_REG_WRITE, a}, 1'b0, 1'b1);
        nx = ulpi_nxt;
        cyc(d, 1'b0, 1'b1);
        cyc(8'h00, 1'b1, 1'b1);
        ulpi_stp = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, output logic nx, output logic [7:0] v);
        #7;
        cyc({ufc_pkg::UFC_CMD_REG_READ, a}, 1'b0, 1'b1);
        nx = ulpi_nxt;
        turn3(v);
    endtask : reg_rd

    task automatic wake(output logic ok);
        #200;
        ulpi_stp = 1'b1;
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            #25;
            ok = (phy_low_power === 1'b0);
        end
        #100;
        ulpi_stp = 1'b0;
    endtask : wake
endmodule : ufc_link_model

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the function control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [5:0] adr_w = ufc_pkg::UFC_ADDR_WRITE;
    localparam logic [5:0] adr_s = ufc_pkg::UFC_ADDR_SET;
    localparam logic [5:0] adr_c = ufc_pkg::UFC_ADDR_CLEAR;
    logic clk, rst_n, ulpi_clk, ulpi_stp, plus_line_pulldown, minus_line_pulldown;
    logic [1:0] line_state, transmit_encoding_sel, transceiver_speed_sel;
    logic [7:0] link_data, ulpi_data_out, function_control, v;
    logic ulpi_data_oe, ulpi_dir, ulpi_nxt, phy_low_power, core_reset, termination_sel;
    logic tx_non_driving, bit_stuff_nrzi_en, auto_sync_eop_en, fs_preamble_en;
    logic fs_pullup_en, hs_term_en, nx, ok;
    wire logic [7:0] ulpi_data_in;
    int errors = 0;
    int samples_checked = 0;

    // The wire carries the device byte only while it drives.
    assign ulpi_data_in = ulpi_data_oe ? ulpi_data_out : link_data;

    ufc_link_model link (.ulpi_clk, .ulpi_stp, .link_data, .ulpi_nxt, .phy_low_power,
        .bus_data(ulpi_data_in));

    ufc_function_control DUT (.clk, .rst_n, .ulpi_clk, .ulpi_stp, .ulpi_data_in,
        .ulpi_data_out, .ulpi_data_oe, .ulpi_dir, .ulpi_nxt, .line_state,
        .plus_line_pulldown, .minus_line_pulldown, .function_control, .phy_low_power,
        .core_reset, .transmit_encoding_sel, .termination_sel, .transceiver_speed_sel,
        .tx_non_driving, .bit_stuff_nrzi_en, .auto_sync_eop_en, .fs_preamble_en,
        .fs_pullup_en, .hs_term_en);

    // ****
    // Tasks
    // ****
    task automatic stop_test;
        if (errors == 0 && samples_checked > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Frames start on a falling clk edge, so link pins never move on a sampling edge.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        link.reg_wr(a, d, nx);
        chk("write nxt", 8'h01, {7'h00, nx});
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        link.reg_rd(a, nx, v);
        chk("read data", e, v);
    endtask : rd

    // Bounded wait, so a device that never returns the bus ends the run.
    task automatic wait_dir_low;
        int n;
        n = 0;
        while (ulpi_dir === 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 200)
        begin
            errors++;
            stop_test();
        end
    endtask : wait_dir_low

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog for anything the bounded waits miss.
    initial
    begin
        #2000000;
        errors++;
        stop_test();
    end

    // ****
    // Scenarios
    // ****
    initial
    begin
        rst_n = 1'b0;
        line_state = 2'h2;
        plus_line_pulldown = 1'b0;
        minus_line_pulldown = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 4; i < 7; i++)
            rd(6'(i), 8'h41);
        for (int i = 0; i < 4; i++)
        begin
            wr(adr_w, {3'h2, 2'(i), 1'b0, 2'(i)});
            rd(adr_w, {3'h2, 2'(i), 1'b0, 2'(i)});
            chk("non-driving", {7'h0, i == 1}, {7'h0, tx_non_driving});
            chk("stuffing", {7'h0, i != 2}, {7'h0, bit_stuff_nrzi_en});
            chk("sync eop", {7'h0, i != 3}, {7'h0, auto_sync_eop_en});
            chk("preamble", {7'h0, i == 3}, {7'h0, fs_preamble_en});
            chk("hs term", {7'h0, i == 0}, {7'h0, hs_term_en});
        end
        wr(adr_c, 8'h1B);
        rd(adr_s, 8'h40);
        wr(adr_s, 8'h84);
        rd(adr_c, 8'hC4);
        chk("pullup", 8'h01, {7'h0, fs_pullup_en});
        plus_line_pulldown <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pullup", 8'h00, {7'h0, fs_pullup_en});
        plus_line_pulldown <= 1'b0;
        minus_line_pulldown <= 1'b1;
        repeat (3) @(posedge clk);
        chk("pullup", 8'h00, {7'h0, fs_pullup_en});
        minus_line_pulldown <= 1'b0;
        wr(6'h07, 8'hFF);
        rd(6'h07, 8'h00);
        rd(adr_w, 8'hC4);
        wr(adr_s, 8'h20);
        chk("core reset", 8'h01, {7'h0, core_reset});
        chk("dir", 8'h01, {7'h0, ulpi_dir});
        wait_dir_low();
        link.turn3(v);
        chk("status", {6'h0, line_state}, v);
        rd(adr_w, 8'hC4);
        wr(adr_c, 8'h40);
        chk("low power", 8'h01, {7'h0, phy_low_power});
        link.wake(ok);
        chk("wake", 8'h01, {7'h0, ok});
        wait_dir_low();
        rd(adr_w, 8'hC4);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(adr_w, 8'h41);
        stop_test();
    end
endmodule : testbench

bind ufc_function_control ufc_fc_chk u_chk (.clk, .rst_n, .ulpi_dir, .function_control,
    .phy_low_power, .core_reset, .transmit_encoding_sel, .termination_sel,
    .transceiver_speed_sel, .tx_non_driving, .auto_sync_eop_en, .fs_preamble_en,
    .hs_term_en);

`default_nettype wire
